// ===== logic/logger_mission_control_regs.sv
// Functional notes
// - conversions spaced by interval minutes, 1..255
// - nonzero interval write starts mission if cleared, uninhibited
// - control writable; write during mission ends it
// - control bit 5 always reads zero
// - oscillator_stop halts oscillator, enters retention
// - no start before RTC advanced one second
// - clear only if command is next access
// - clear zeroes memories, delay and interval
// - any memory command drops clear_permit
// - mission_inhibit high blocks mission start
// - wrap enabled: full datalog overwrites oldest
// - wrap disabled: stop storing, keep mission running
// - low search answers on low flag
// - timer search answers on timer alarm flag
// - 16-bit start delay in minutes before logging
// - status write ends mission only when bit 5 written zero
// - status bit order fixed, bit 3 zero
// - status flags clear-only, bit 5 write-zero ends mission, other bits read-only
// - first write into 200h-213h ends mission
// - mission start clears cleared_flag
module logger_mission_control_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [logger_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic dev_access,
  input wire logic mem_cmd,
  input wire logic mem_cmd_clear,
  input wire logic rtc_second_tick,
  input wire logic minute_tick,
  input wire logic conv_busy,
  input wire logic low_event,
  input wire logic high_event,
  input wire logic timer_event,
  input wire logic datalog_full,
  output logic osc_run,
  output logic retention_mode,
  output logic clear_memory,
  output logic sample_start,
  output logic datalog_store,
  output logic datalog_wrap,
  output logic search_match,
  output logic mission_active,
  output logic logging_started
);
  import logger_regs_pkg::*;

  // ***********************************************************
  // state
  // ***********************************************************
  typedef struct packed {
    logic [7:0] interval;
    logic [7:0] control;
    logic [15:0] start_delay;
    logic cleared;
    logic active;
    logic sampling;
    logic low_flag;
    logic high_flag;
    logic timer_flag;
    logic conv_idle;
    logic rtc_advanced;
    logic clear_armed;
    mission_state_t state;
    logic [15:0] delay_left;
    logic [7:0] minutes_left;
    logic [7:0] rdata;
    logic clear_pulse;
    logic sample_pulse;
    logic store_pulse;
    logic match;
    logic logging;
    logic run;
  } regs_t;

  regs_t q;
  regs_t d;
  logic rst_meta_q;
  logic rst_sync_q;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic in_mission_window(input logic [ADDR_W-1:0] a);
    in_mission_window = (a >= OFS_MISSION_WIN_LO) && (a <= OFS_MISSION_WIN_HI);
  endfunction : in_mission_window

  function automatic logic [7:0] status_byte(input regs_t s);
    status_byte = 8'h00;
    status_byte[STS_CONV_IDLE] = s.conv_idle;
    status_byte[STS_CLEARED] = s.cleared;
    status_byte[STS_MISSION_ACTIVE] = s.active;
    status_byte[STS_SAMPLING] = s.sampling;
    status_byte[STS_LOW_FLAG] = s.low_flag;
    status_byte[STS_HIGH_FLAG] = s.high_flag;
    status_byte[STS_TIMER_FLAG] = s.timer_flag;
  endfunction : status_byte

  // ***********************************************************
  // reset release
  // ***********************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    logic wr_interval;
    logic wr_control;
    logic wr_status;
    logic end_mission;
    logic start_mission;
    logic do_clear;
    logic osc_on;
    logic wr_delay_lo;
    logic wr_delay_hi;
    wr_interval = wr && (addr == OFS_LOGGING_INTERVAL);
    wr_control = wr && (addr == OFS_MISSION_CONTROL);
    wr_status = wr && (addr == OFS_MISSION_STATUS);
    wr_delay_lo = wr && (addr == OFS_START_DELAY_LO);
    wr_delay_hi = wr && (addr == OFS_START_DELAY_HI);
    d = q;
    d.clear_pulse = 1'b0;
    d.sample_pulse = 1'b0;
    d.store_pulse = 1'b0;
    osc_on = !q.control[CTL_OSC_STOP];

    // ***********************************************************
    // oscillator must have ticked once since it started
    // ***********************************************************
    if (!osc_on)
      d.rtc_advanced = 1'b0;
    else if (rtc_second_tick)
      d.rtc_advanced = 1'b1;

    // ***********************************************************
    // mission end: window write or control write, status write only via bit 5
    // ***********************************************************
    end_mission = q.active && ((wr && in_mission_window(addr)) || wr_control);
    if (q.active && wr_status && !wdata[STS_MISSION_ACTIVE])
      end_mission = 1'b1;

    start_mission = wr_interval && (wdata != 8'h00) && q.cleared
      && !q.control[CTL_MISSION_INHIBIT] && q.rtc_advanced && !q.active;

    // ***********************************************************
    // register writes
    // ***********************************************************
    if (wr_interval)
      d.interval = wdata;
    if (wr_control)
      d.control = wdata & CTL_WRITE_MASK;
    if (wr_delay_lo)
      d.start_delay[7:0] = wdata;
    if (wr_delay_hi)
      d.start_delay[15:8] = wdata;

    // ***********************************************************
    // clear sequence: permit armed by the control write, lost on any other access
    // ***********************************************************
    // clear refused during a mission so a running log cannot be wiped
    if (wr_control)
      d.clear_armed = wdata[CTL_CLEAR_PERMIT];
    else if (rd || wr || dev_access || mem_cmd)
      d.clear_armed = 1'b0;
    do_clear = mem_cmd && mem_cmd_clear && q.clear_armed
      && q.control[CTL_CLEAR_PERMIT] && !q.active;
    if (mem_cmd)
      d.control[CTL_CLEAR_PERMIT] = 1'b0;
    if (do_clear)
    begin
      d.interval = 8'h00;
      d.start_delay = 16'h0000;
      d.cleared = 1'b1;
      d.clear_pulse = 1'b1;
    end

    // ***********************************************************
    // status flag writes, clear only; a same-cycle event wins
    // ***********************************************************
    if (wr_status)
    begin
      if (!wdata[STS_LOW_FLAG])
        d.low_flag = 1'b0;
      if (!wdata[STS_HIGH_FLAG])
        d.high_flag = 1'b0;
      if (!wdata[STS_TIMER_FLAG])
        d.timer_flag = 1'b0;
    end
    if (q.active && low_event)
      d.low_flag = 1'b1;
    if (q.active && high_event)
      d.high_flag = 1'b1;
    if (timer_event)
      d.timer_flag = 1'b1;
    d.conv_idle = !conv_busy;
    // own flop for the pin, so no inverter sits between register and output
    d.run = !d.control[CTL_OSC_STOP];

    // ***********************************************************
    // mission sequencer
    // ***********************************************************
    case (q.state)
      MS_IDLE:
      begin
        if (start_mission)
        begin
          d.active = 1'b1;
          d.cleared = 1'b0;
          d.delay_left = q.start_delay;
          d.state = MS_DELAY;
        end
      end
      MS_DELAY:
      begin
        if (minute_tick && osc_on)
        begin
          if (q.delay_left == 16'h0000)
          begin
            d.state = MS_LOGGING;
            d.logging = 1'b1;
            d.sample_pulse = 1'b1;
            d.minutes_left = q.interval;
          end
          else
          begin
            d.delay_left = q.delay_left - 16'h0001;
          end
        end
      end
      MS_LOGGING:
      begin
        if (minute_tick && osc_on)
        begin
          if (q.minutes_left <= 8'h01)
          begin
            d.sample_pulse = 1'b1;
            d.minutes_left = q.interval;
          end
          else
          begin
            d.minutes_left = q.minutes_left - 8'h01;
          end
        end
      end
      default:
        d.state = MS_IDLE;
    endcase
    if (end_mission)
    begin
      d.active = 1'b0;
      d.logging = 1'b0;
      d.sample_pulse = 1'b0;
      d.state = MS_IDLE;
    end

    // ***********************************************************
    // full log without wrap stops storing only; mission carries on
    // ***********************************************************
    if (d.sample_pulse)
      d.store_pulse = q.control[CTL_WRAP_LOG] || !datalog_full;
    d.sampling = q.active && (d.sample_pulse || (q.sampling && conv_busy));

    d.match = (q.control[CTL_LOW_SEARCH] && q.low_flag)
      || (q.control[CTL_HIGH_SEARCH] && q.high_flag)
      || (q.control[CTL_TIMER_SEARCH] && q.timer_flag);

    // ***********************************************************
    // read data for the next cycle only
    // ***********************************************************
    // unmapped addresses and idle cycles read zero
    d.rdata = RST_READ_DATA;
    if (rd)
    begin
      case (addr)
        OFS_LOGGING_INTERVAL:
        begin
          d.rdata = q.interval;
        end
        OFS_MISSION_CONTROL:
        begin
          d.rdata = q.control & CTL_WRITE_MASK;
        end
        OFS_START_DELAY_LO:
        begin
          d.rdata = q.start_delay[7:0];
        end
        OFS_START_DELAY_HI:
        begin
          d.rdata = q.start_delay[15:8];
        end
        OFS_MISSION_STATUS:
        begin
          d.rdata = status_byte(q);
        end
        default:
        begin
          d.rdata = RST_READ_DATA;
        end
      endcase
    end
  end

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      // cleared_flag starts low: a clear is needed before the first mission
      q.cleared <= 1'b0;
      q.active <= 1'b0;
      q.sampling <= 1'b0;
      q.low_flag <= 1'b0;
      q.high_flag <= 1'b0;
      q.timer_flag <= 1'b0;
      q.rtc_advanced <= 1'b0;
      q.clear_armed <= 1'b0;
      q.delay_left <= 16'h0000;
      q.minutes_left <= 8'h00;
      q.clear_pulse <= 1'b0;
      q.sample_pulse <= 1'b0;
      q.store_pulse <= 1'b0;
      q.match <= 1'b0;
      q.logging <= 1'b0;
      q.run <= 1'b1;
      q.interval <= RST_LOGGING_INTERVAL;
      q.control <= RST_MISSION_CONTROL;
      q.start_delay <= RST_START_DELAY;
      q.conv_idle <= 1'b1;
      q.state <= MS_IDLE;
      q.rdata <= RST_READ_DATA;
    end
    else
      q <= d;
  end

  // ***********************************************************
  // outputs, all straight from flops
  // ***********************************************************
  assign rdata = q.rdata;
  assign osc_run = q.run;
  assign retention_mode = q.control[CTL_OSC_STOP];
  assign clear_memory = q.clear_pulse;
  assign sample_start = q.sample_pulse;
  assign datalog_store = q.store_pulse;
  // a wrapping log overwrites oldest samples; staggered missions want it off
  assign datalog_wrap = q.control[CTL_WRAP_LOG];
  assign search_match = q.match;
  assign mission_active = q.active;
  assign logging_started = q.logging;

endmodule : logger_mission_control_regs

// ===== logic/logger_regs_pkg.sv
package logger_regs_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] OFS_LOGGING_INTERVAL = 10'h20D;
  localparam logic [ADDR_W-1:0] OFS_MISSION_CONTROL = 10'h20E;
  localparam logic [ADDR_W-1:0] OFS_START_DELAY_LO = 10'h212;
  localparam logic [ADDR_W-1:0] OFS_START_DELAY_HI = 10'h213;
  localparam logic [ADDR_W-1:0] OFS_MISSION_STATUS = 10'h214;
  // writes anywhere in this window end a running mission
  localparam logic [ADDR_W-1:0] OFS_MISSION_WIN_LO = 10'h200;
  localparam logic [ADDR_W-1:0] OFS_MISSION_WIN_HI = 10'h213;

  // ***********************************************************
  // control field positions
  // ***********************************************************
  localparam int CTL_OSC_STOP = 7;
  localparam int CTL_CLEAR_PERMIT = 6;
  localparam int CTL_UNUSED = 5;
  localparam int CTL_MISSION_INHIBIT = 4;
  localparam int CTL_WRAP_LOG = 3;
  localparam int CTL_LOW_SEARCH = 2;
  localparam int CTL_HIGH_SEARCH = 1;
  localparam int CTL_TIMER_SEARCH = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hDF;

  // ***********************************************************
  // status field positions
  // ***********************************************************
  localparam int STS_CONV_IDLE = 7;
  localparam int STS_CLEARED = 6;
  localparam int STS_MISSION_ACTIVE = 5;
  localparam int STS_SAMPLING = 4;
  localparam int STS_UNUSED = 3;
  localparam int STS_LOW_FLAG = 2;
  localparam int STS_HIGH_FLAG = 1;
  localparam int STS_TIMER_FLAG = 0;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0] RST_LOGGING_INTERVAL = 8'h00;
  localparam logic [7:0] RST_MISSION_CONTROL = 8'h00;
  localparam logic [15:0] RST_START_DELAY = 16'h0000;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ***********************************************************
  // mission sequencer states
  // ***********************************************************
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_DELAY = 3'b010,
    MS_LOGGING = 3'b100
  } mission_state_t;

endpackage : logger_regs_pkg

// ===== verif/mc_regs_assertions.sv
module mc_regs_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [logger_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic mem_cmd,
  input wire logic mem_cmd_clear,
  input wire logic minute_tick,
  input wire logic datalog_full,
  input wire logic osc_run,
  input wire logic retention_mode,
  input wire logic clear_memory,
  input wire logic sample_start,
  input wire logic datalog_store,
  input wire logic datalog_wrap,
  input wire logic mission_active
);
  timeunit 1ns;
  timeprecision 1ps;
  import logger_regs_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ****************
  // assertions
  // ****************
  chk_osc_retention: assert property (retention_mode == !osc_run)
    else $error("retention_mode is not the inverse of osc_run");
  chk_osc_no_sample: assert property (!osc_run && minute_tick |=> !sample_start)
    else $error("sample started while oscillator stopped");
  chk_ctl_bit5_zero: assert property (rd && addr == OFS_MISSION_CONTROL |=> !rdata[CTL_UNUSED])
    else $error("control bit 5 read as one");
  chk_status_layout: assert property (rd && addr == OFS_MISSION_STATUS |=>
    !rdata[STS_UNUSED] && rdata[STS_MISSION_ACTIVE] == mission_active)
    else $error("status read layout wrong");
  chk_ctl_wr_ends: assert property (mission_active && wr && addr == OFS_MISSION_CONTROL
    |=> !mission_active) else $error("control write did not end mission");
  chk_win_wr_ends: assert property (mission_active && wr && addr >= OFS_MISSION_WIN_LO
    && addr <= OFS_MISSION_WIN_HI |=> !mission_active) else $error("window write kept mission");
  chk_status_keeps: assert property (mission_active && wr && addr == OFS_MISSION_STATUS
    && wdata[STS_MISSION_ACTIVE] |=> mission_active) else $error("status write ended mission");
  chk_start_cause: assert property ($rose(mission_active) |->
    $past(wr && addr == OFS_LOGGING_INTERVAL && wdata != 8'h00))
    else $error("mission began without interval write");
  chk_clear_cause: assert property (clear_memory |-> $past(mem_cmd && mem_cmd_clear))
    else $error("clear pulse without clear command");
  chk_wrap_store: assert property (sample_start && datalog_wrap |-> datalog_store)
    else $error("sample not stored with wrap on");
  chk_full_stop: assert property (sample_start && !datalog_wrap && $past(datalog_full)
    |-> !datalog_store) else $error("sample stored into full log");
  cov_start: cover property ($rose(mission_active));
  cov_clear: cover property (clear_memory);
  cov_sample: cover property (sample_start && datalog_store);
endmodule : mc_regs_checker

bind logger_mission_control_regs mc_regs_checker mc_regs_checker_i (.clk, .nrst, .addr,
  .wdata, .wr, .rd, .rdata, .mem_cmd, .mem_cmd_clear, .minute_tick, .datalog_full, .osc_run,
  .retention_mode, .clear_memory, .sample_start, .datalog_store, .datalog_wrap,
  .mission_active);

// ===== verif/logger_tick_model.sv
module logger_tick_model #(
  parameter int SEC_CYC = 400
) (
  input wire logic clk,
  input wire logic osc_run,
  input wire logic tick_req,
  output logic minute_tick,
  output logic rtc_second_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial
  begin
    minute_tick = 1'b0;
    rtc_second_tick = 1'b0;
  end
  // a stopped oscillator freezes seconds and minutes alike
  always @(posedge clk)
  begin
    cnt <= (osc_run && cnt != SEC_CYC - 1) ? cnt + 1 : 0;
    rtc_second_tick <= osc_run && cnt == SEC_CYC - 1;
    minute_tick <= osc_run && tick_req;
  end
endmodule : logger_tick_model

// ===== verif/test_logger_mission_control_regs.sv
module test_logger_mission_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import logger_regs_pkg::*;
  localparam int EV_DEV = 0;
  localparam int EV_LOW = 1;
  localparam int EV_HIGH = 2;
  localparam int EV_TIMER = 3;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, mem_cmd = 0, mem_cmd_clear = 0;
  logic tick_req = 0, conv_busy = 0, smp, sto;
  logic [3:0] ev = 4'h0;
  logic datalog_full = 0, minute_tick, rtc_second_tick, osc_run, retention_mode;
  logic clear_memory, sample_start, datalog_store, datalog_wrap, search_match;
  logic mission_active, logging_started;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00, rdata;
  int err_count = 0, tests_run = 0;
  always #20 clk = !clk;
  logger_tick_model logger_tick_model_i (.clk(clk), .osc_run(osc_run), .tick_req(tick_req),
    .minute_tick(minute_tick), .rtc_second_tick(rtc_second_tick));
  logger_mission_control_regs logger_mission_control_regs_i (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dev_access(ev[EV_DEV]),
    .mem_cmd(mem_cmd), .mem_cmd_clear(mem_cmd_clear), .rtc_second_tick(rtc_second_tick),
    .minute_tick(minute_tick), .conv_busy(conv_busy), .low_event(ev[EV_LOW]),
    .high_event(ev[EV_HIGH]), .timer_event(ev[EV_TIMER]), .datalog_full(datalog_full),
    .osc_run(osc_run), .retention_mode(retention_mode), .clear_memory(clear_memory),
    .sample_start(sample_start), .datalog_store(datalog_store), .datalog_wrap(datalog_wrap),
    .search_match(search_match), .mission_active(mission_active),
    .logging_started(logging_started));
  // ****************
  // tasks
  // ****************
  task report_and_stop;
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rd_chk
  task clr(input logic e);
    @(posedge clk);
    mem_cmd <= 1'b1;
    mem_cmd_clear <= 1'b1;
    @(posedge clk);
    mem_cmd <= 1'b0;
    mem_cmd_clear <= 1'b0;
    #1;
    chk("clear_memory", 8'(clear_memory), 8'(e));
  endtask : clr
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
  // sample_start stands one cycle only: catch it right after the tick is taken
  task tick(output logic s, output logic st);
    @(posedge clk);
    tick_req <= 1'b1;
    @(posedge clk);
    tick_req <= 1'b0;
    @(posedge clk);
    #1;
    s = sample_start;
    st = datalog_store;
    repeat (2) @(posedge clk);
    #1;
  endtask : tick
  // ****************
  // sequence
  // ****************
  initial
  begin
    #2000000;
    err_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(OFS_LOGGING_INTERVAL, 8'h00);
    rd_chk(OFS_MISSION_STATUS, 8'h80);
    rd_chk(10'h215, 8'h00);
    conv_busy <= 1'b1;
    rd_chk(OFS_MISSION_STATUS, 8'h00);
    conv_busy <= 1'b0;
    wr_reg(OFS_MISSION_CONTROL, 8'hBF);
    rd_chk(OFS_MISSION_CONTROL, 8'h9F);
    wr_reg(OFS_MISSION_STATUS, 8'hFF);
    rd_chk(OFS_MISSION_STATUS, 8'h80);
    wr_reg(OFS_START_DELAY_LO, 8'h12);
    wr_reg(OFS_START_DELAY_HI, 8'h34);
    wr_reg(OFS_LOGGING_INTERVAL, 8'h05);
    chk("mission_active", 8'(mission_active), 8'h00);
    wr_reg(OFS_MISSION_CONTROL, 8'h40);
    pulse(EV_DEV);
    clr(1'b0);
    rd_chk(OFS_MISSION_CONTROL, 8'h00);
    wr_reg(OFS_MISSION_CONTROL, 8'h40);
    clr(1'b1);
    rd_chk(OFS_MISSION_CONTROL, 8'h00);
    rd_chk(OFS_MISSION_STATUS, 8'hC0);
    rd_chk(OFS_LOGGING_INTERVAL, 8'h00);
    rd_chk(OFS_START_DELAY_HI, 8'h00);
    wr_reg(OFS_LOGGING_INTERVAL, 8'h02);
    chk("early start", 8'(mission_active), 8'h00);
    repeat (420) @(posedge clk);
    wr_reg(OFS_MISSION_CONTROL, 8'h1C);
    wr_reg(OFS_LOGGING_INTERVAL, 8'h03);
    chk("inhibited", 8'(mission_active), 8'h00);
    wr_reg(OFS_MISSION_CONTROL, 8'h0C);
    wr_reg(OFS_START_DELAY_LO, 8'h01);
    datalog_full <= 1'b1;
    wr_reg(OFS_LOGGING_INTERVAL, 8'h02);
    rd_chk(OFS_MISSION_STATUS, 8'hA0);
    for (int k = 0; k < 8; k++)
    begin
      tick(smp, sto);
      chk("sample_start", 8'(smp), 8'(k % 2 == 1));
      chk("datalog_store", 8'(sto), 8'(k % 2 == 1));
    end
    chk("logging_started", 8'(logging_started), 8'h01);
    pulse(EV_LOW);
    chk("search low", 8'(search_match), 8'h01);
    wr_reg(OFS_MISSION_STATUS, 8'hFF);
    wr_reg(OFS_MISSION_STATUS, 8'h20);
    rd_chk(OFS_MISSION_STATUS, 8'hA0);
    pulse(EV_TIMER);
    chk("search off", 8'(search_match), 8'h00);
    wr_reg(OFS_MISSION_CONTROL, 8'h03);
    chk("ctl end", 8'(mission_active), 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk("search timer", 8'(search_match), 8'h01);
    rd_chk(OFS_MISSION_STATUS, 8'h81);
    wr_reg(OFS_MISSION_CONTROL, 8'h40);
    clr(1'b1);
    wr_reg(OFS_LOGGING_INTERVAL, 8'h01);
    chk("window start", 8'(mission_active), 8'h01);
    wr_reg(OFS_START_DELAY_HI, 8'h00);
    chk("window end", 8'(mission_active), 8'h00);
    wr_reg(OFS_MISSION_CONTROL, 8'h42);
    clr(1'b1);
    wr_reg(OFS_LOGGING_INTERVAL, 8'h01);
    chk("full start", 8'(mission_active), 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      tick(smp, sto);
      chk("full sample", 8'(smp), 8'h01);
      chk("full store", 8'(sto), 8'h00);
    end
    chk("full keeps", 8'(mission_active), 8'h01);
    pulse(EV_HIGH);
    chk("search high", 8'(search_match), 8'h01);
    wr_reg(OFS_MISSION_CONTROL, 8'h80);
    chk("retention", 8'({osc_run, retention_mode}), 8'h01);
    report_and_stop();
  end
endmodule : test_logger_mission_control_regs
